//--- hdl/iofm_pkg.sv
// Constants for the configurable I/O function map
package iofm_pkg;
   // ****************************************
   // Parameter addresses and status words
   // ****************************************
   localparam logic [15:0] ADDR_INPUT_LEVEL  = 16'h081e;
   localparam logic [15:0] ADDR_OUTPUT_LEVEL = 16'h0820;
   localparam logic [15:0] STATUS_RESET      = 16'h0000;
   localparam int          STATUS_WIDTH      = 16;
   localparam int          NUM_INPUTS        = 7;
   localparam int          NUM_OUTPUTS       = 3;
   localparam int          NUM_CFG_INPUTS    = 4;

   // ****************************************
   // Start-up operating modes
   // ****************************************
   localparam logic [2:0] MODE_JOG      = 3'h0;
   localparam logic [2:0] MODE_GEAR     = 3'h1;
   localparam logic [2:0] MODE_SPEED    = 3'h2;
   localparam logic [2:0] MODE_CURRENT  = 3'h3;
   localparam logic [2:0] MODE_SEQUENCE = 3'h4;
   localparam logic [2:0] MODE_FIELDBUS = 3'h5;

   // ****************************************
   // Input function codes
   // ****************************************
   localparam logic [3:0] IN_NONE        = 4'h0;
   localparam logic [3:0] IN_FAULT_RESET = 4'h1;
   localparam logic [3:0] IN_HALT        = 4'h2;
   localparam logic [3:0] IN_JOG_POS     = 4'h3;
   localparam logic [3:0] IN_JOG_NEG     = 4'h4;
   localparam logic [3:0] IN_JOG_FAST    = 4'h5;
   localparam logic [3:0] IN_ENABLE2     = 4'h6;
   localparam logic [3:0] IN_START       = 4'h7;
   localparam logic [3:0] IN_REF         = 4'h8;
   localparam logic [3:0] IN_NEGATIVE_LIMIT_SWITCH        = 4'h9;
   localparam logic [3:0] IN_POSITIVE_LIMIT_SWITCH        = 4'ha;
   localparam logic [3:0] IN_LAST_FREE   = 4'ha;
   localparam int          IN_FN_COUNT   = 11;

   // ****************************************
   // Output function codes
   // ****************************************
   localparam logic [2:0] OUT_NONE      = 3'h0;
   localparam logic [2:0] OUT_NO_FAULT  = 3'h1;
   localparam logic [2:0] OUT_START_ACK = 3'h2;
   localparam logic [2:0] OUT_BRAKE     = 3'h3;
   localparam logic [2:0] OUT_ACTIVE    = 3'h4;
   localparam logic [2:0] OUT_LAST      = 3'h4;
endpackage : iofm_pkg

//--- hdl/iofm_top.sv
// Configurable I/O function map with live level status words
//
// Behaviour
// [RULE1] Inputs 1,2,4,7 and outputs 1-3 routed by selects
// [RULE2] Enable input always drives power-stage enable
// [RULE3] Both shutdown inputs always trigger power removal
// [RULE4] Defaults come from per-mode table
// [RULE5] Input status word, input one at bit 0
// [RULE6] Output status word, output one at bit 0
// [RULE7] Input one defaults per mode
// [RULE8] Input two defaults per mode
// [RULE9] Fixed pins and functions cannot be reassigned
// [RULE10] Mode change reloads defaults at power-up
// [RULE11] Brake-release function drives brake controller
// [RULE12] Status sampled every cycle, unused bits zero
`timescale 1ns/1ps
`default_nettype none
module iofm_top
   import iofm_pkg::*;
#(
   parameter int STATUS_W = STATUS_WIDTH
) (
   input  wire logic        clk_i,                        // 200 MHz clock
   input  wire logic        reset_n_i,                    // Async reset, low
   input  wire logic        clk_en_i,                     // Freezes state when low
   input  wire logic        digital_input_one_i,          // Pin input 1
   input  wire logic        digital_input_two_i,          // Pin input 2
   input  wire logic        digital_input_three_i,        // Enable pin
   input  wire logic        digital_input_four_i,         // Pin input 4
   input  wire logic        safety_shutdown_input_a_i,    // Shutdown A, low active
   input  wire logic        safety_shutdown_input_b_i,    // Shutdown B, low active
   input  wire logic        digital_input_seven_i,        // Pin input 7
   input  wire logic [2:0]  startup_mode_i,               // Start-up mode
   input  wire logic [2:0]  stored_mode_i,                // Mode of last map save
   input  wire logic [3:0]  input_one_function_select_i,  // Select for input 1
   input  wire logic [3:0]  input_two_function_select_i,  // Select for input 2
   input  wire logic [3:0]  input_four_function_select_i, // Select for input 4
   input  wire logic [3:0]  input_seven_function_select_i,// Select for input 7
   input  wire logic [2:0]  output_one_function_select_i, // Select for output 1
   input  wire logic [2:0]  output_two_function_select_i, // Select for output 2
   input  wire logic [2:0]  output_three_function_select_i,// Select for output 3
   input  wire logic        select_load_i,                // Apply selects, pulse
   input  wire logic        no_fault_i,                   // Core: no fault
   input  wire logic        start_ack_i,                  // Core: start acknowledge
   input  wire logic        brake_release_i,              // Core: release brake
   input  wire logic        active_i,                     // Core: drive active
   input  wire logic        param_rd_i,                   // Parameter read, pulse
   input  wire logic [15:0] param_addr_i,                 // Parameter address
   output logic [IN_FN_COUNT-1:0] input_function_o,       // Level per input code
   output logic             power_stage_enable_o,         // Enable function
   output logic             safe_power_removal_o,         // Power removal request
   output logic             digital_output_one_o,         // Pin output 1
   output logic             digital_output_two_o,         // Pin output 2
   output logic             digital_output_three_o,       // Pin output 3
   output logic             map_reloaded_o,               // Defaults loaded on mode change, pulse
   output logic             param_ack_o,                  // Read answer, pulse
   output logic             param_err_o,                  // Unmapped address
   output logic [15:0]      param_rdata_o                 // Read data
);
   // ****************************************
   // Elaboration check
   // ****************************************
   if (STATUS_W != STATUS_WIDTH) begin : g_bad_width
      $error("Status word must be 16 bits");
   end

   // ****************************************
   // State
   // ****************************************
   typedef enum logic [0:0] {ST_POWERUP, ST_RUN} iofm_state_e;

   typedef struct packed {
      iofm_state_e            st;
      logic [3:0][3:0]        in_sel;
      logic [2:0][2:0]        out_sel;
      logic [15:0]            in_status;
      logic [15:0]            out_status;
      logic [IN_FN_COUNT-1:0] in_fn;
      logic                   enable;
      logic                   removal;
      logic [2:0]             dout;
      logic                   reloaded;
      logic                   ack;
      logic                   err;
      logic [15:0]            rdata;
   } iofm_state_s;

   iofm_state_s r;
   iofm_state_s next_r;

   // Default input function for a mode and configurable slot
   function automatic logic [3:0] default_in(input logic [2:0] mode, input int slot);
      logic seq_fb;
      seq_fb = (mode == MODE_SEQUENCE) || (mode == MODE_FIELDBUS);
      default_in = IN_NONE;
      case (slot)
         0: default_in = (mode == MODE_JOG) ? IN_JOG_NEG : // see [RULE7]
                         seq_fb ? IN_REF : IN_NONE;
         1: default_in = (mode == MODE_JOG) ? IN_JOG_POS : // see [RULE8]
                         seq_fb ? IN_NEGATIVE_LIMIT_SWITCH : IN_FAULT_RESET;
         2: default_in = (mode == MODE_JOG) ? IN_JOG_FAST :
                         (mode == MODE_SEQUENCE) ? IN_START : IN_HALT;
         3: default_in = (mode == MODE_FIELDBUS) ? IN_NONE : IN_ENABLE2;
         default: default_in = IN_NONE;
      endcase
   endfunction : default_in

   // Default output function for a mode and output slot
   function automatic logic [2:0] default_out(input logic [2:0] mode, input int slot);
      default_out = OUT_NONE;
      case (slot)
         0: default_out = (mode == MODE_SEQUENCE) ? OUT_START_ACK : OUT_NO_FAULT;
         1: default_out = OUT_BRAKE;
         2: default_out = OUT_ACTIVE;
         default: default_out = OUT_NONE;
      endcase
   endfunction : default_out

   // Level of the internal signal chosen for an output
   function automatic logic out_source(input logic [2:0] code, input logic [3:0] src);
      case (code)
         OUT_NO_FAULT:  out_source = src[0];
         OUT_START_ACK: out_source = src[1];
         OUT_BRAKE:     out_source = src[2];
         OUT_ACTIVE:    out_source = src[3];
         default:       out_source = 1'b0;
      endcase
   endfunction : out_source

   // ****************************************
   // Next-state logic
   // ****************************************
   logic [3:0]      cfg_pin;
   logic [3:0][3:0] sel_in;
   logic [2:0][2:0] sel_out;
   logic [3:0]      out_src;
   logic [6:0]      pins;

   assign cfg_pin = {digital_input_seven_i, digital_input_four_i,
                     digital_input_two_i, digital_input_one_i};
   assign sel_in  = {input_seven_function_select_i, input_four_function_select_i,
                     input_two_function_select_i, input_one_function_select_i};
   assign sel_out = {output_three_function_select_i, output_two_function_select_i,
                     output_one_function_select_i};
   assign out_src = {active_i, brake_release_i, start_ack_i, no_fault_i};
   assign pins    = {digital_input_seven_i, safety_shutdown_input_b_i,
                     safety_shutdown_input_a_i, digital_input_four_i,
                     digital_input_three_i, digital_input_two_i, digital_input_one_i};

   // Map loading, function routing, status sampling and parameter reads
   always_comb begin
      next_r          = r;
      if (clk_en_i) begin
         // Pulses last one enabled cycle and hold while frozen
         next_r.reloaded = 1'b0;
         next_r.ack      = 1'b0;
         case (r.st)
            ST_POWERUP: begin
               // Changed mode or an out-of-range saved select loads table defaults, else saved selects
               for (int i = 0; i < NUM_CFG_INPUTS; i++) begin
                  next_r.in_sel[i] = (startup_mode_i != stored_mode_i ||
                     sel_in[i] > IN_LAST_FREE) ?
                     default_in(startup_mode_i, i) : sel_in[i];        // see [RULE4] [RULE10]
               end
               for (int j = 0; j < NUM_OUTPUTS; j++) begin
                  next_r.out_sel[j] = (startup_mode_i != stored_mode_i ||
                     sel_out[j] > OUT_LAST) ?
                     default_out(startup_mode_i, j) : sel_out[j];      // see [RULE4]
               end
               next_r.reloaded = (startup_mode_i != stored_mode_i);    // see [RULE10]
               next_r.st       = ST_RUN;
            end
            ST_RUN: begin
               // Only free codes are accepted; fixed functions are refused
               if (select_load_i) begin
                  for (int i = 0; i < NUM_CFG_INPUTS; i++) begin
                     if (sel_in[i] <= IN_LAST_FREE) begin
                        next_r.in_sel[i] = sel_in[i];                  // see [RULE1] [RULE9]
                     end
                  end
                  for (int j = 0; j < NUM_OUTPUTS; j++) begin
                     if (sel_out[j] <= OUT_LAST) begin
                        next_r.out_sel[j] = sel_out[j];                // see [RULE1]
                     end
                  end
               end
            end
            default: next_r.st = ST_POWERUP;
         endcase

         // Route configurable pins onto their chosen functions
         next_r.in_fn = '0;
         for (int i = 0; i < NUM_CFG_INPUTS; i++) begin
            next_r.in_fn[r.in_sel[i]] = next_r.in_fn[r.in_sel[i]] | cfg_pin[i]; // see [RULE1]
         end
         next_r.in_fn[IN_NONE] = 1'b0;
         if (startup_mode_i == MODE_FIELDBUS) begin
            next_r.in_fn[IN_POSITIVE_LIMIT_SWITCH] = next_r.in_fn[IN_POSITIVE_LIMIT_SWITCH] | digital_input_three_i;
         end
         next_r.enable  = digital_input_three_i;                       // see [RULE2]
         next_r.removal = ~safety_shutdown_input_a_i |
                          ~safety_shutdown_input_b_i;                 // see [RULE3] [RULE9]
         for (int j = 0; j < NUM_OUTPUTS; j++) begin
            next_r.dout[j] = out_source(r.out_sel[j], out_src);        // see [RULE1] [RULE11]
         end

         // Live status words, unused bits zero
         next_r.in_status  = {9'h000, pins};                           // see [RULE5] [RULE12]
         next_r.out_status = {13'h0000, r.dout};                       // see [RULE6] [RULE12]

         // Parameter read answer
         if (param_rd_i) begin
            next_r.ack   = 1'b1;
            next_r.err   = 1'b0;
            next_r.rdata = 16'h0000;
            if (param_addr_i == ADDR_INPUT_LEVEL) begin
               next_r.rdata = r.in_status;
            end else if (param_addr_i == ADDR_OUTPUT_LEVEL) begin
               next_r.rdata = r.out_status;
            end else begin
               next_r.err = 1'b1;
            end
         end
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r            <= '0;
         r.st         <= ST_POWERUP;
         r.in_status  <= STATUS_RESET;
         r.out_status <= STATUS_RESET;
      end else begin
         r <= next_r;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign input_function_o       = r.in_fn;
   assign power_stage_enable_o   = r.enable;
   assign safe_power_removal_o   = r.removal;
   assign digital_output_one_o   = r.dout[0];
   assign digital_output_two_o   = r.dout[1];
   assign digital_output_three_o = r.dout[2];
   assign map_reloaded_o         = r.reloaded;
   assign param_ack_o            = r.ack;
   assign param_err_o            = r.err;
   assign param_rdata_o          = r.rdata;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_powerup_changed;
      r.st == ST_POWERUP && clk_en_i && startup_mode_i != stored_mode_i;
   endsequence

   sequence s_load_valid_one;
      r.st == ST_RUN && clk_en_i && select_load_i &&
         input_one_function_select_i <= IN_LAST_FREE;
   endsequence

   chk_route_select: assert property (s_load_valid_one |=> // see [RULE1]
      r.in_sel[0] == $past(input_one_function_select_i))
      else $error("input one select not applied");
   chk_enable_fixed: assert property (clk_en_i |=> // see [RULE2]
      power_stage_enable_o == $past(digital_input_three_i))
      else $error("enable not following its pin");
   chk_removal_fixed: assert property (clk_en_i |=> // see [RULE3]
      safe_power_removal_o == !($past(safety_shutdown_input_a_i) &&
                                $past(safety_shutdown_input_b_i)))
      else $error("power removal not following shutdown pins");
   chk_seq_defaults: assert property (s_powerup_changed and // see [RULE4]
      startup_mode_i == MODE_SEQUENCE |=> r.in_sel[2] == IN_START &&
      r.out_sel[0] == OUT_START_ACK) else $error("sequence defaults wrong");
   chk_input_status: assert property (clk_en_i |=> // see [RULE5]
      r.in_status[0] == $past(digital_input_one_i) &&
      r.in_status[3] == $past(digital_input_four_i))
      else $error("input status bits wrong");
   chk_output_status: assert property (clk_en_i |=> // see [RULE6]
      r.out_status == {13'h0000, $past(r.dout)}) else $error("output status wrong");
   chk_one_defaults: assert property (s_powerup_changed and // see [RULE7]
      startup_mode_i == MODE_JOG |=> r.in_sel[0] == IN_JOG_NEG)
      else $error("input one jog default wrong");
   chk_two_defaults: assert property (s_powerup_changed and // see [RULE8]
      startup_mode_i == MODE_GEAR |=> r.in_sel[1] == IN_FAULT_RESET)
      else $error("input two gear default wrong");
   chk_fixed_refused: assert property (r.st == ST_RUN && clk_en_i && // see [RULE9]
      input_two_function_select_i > IN_LAST_FREE |=> r.in_sel[1] == $past(r.in_sel[1]))
      else $error("fixed function accepted");
   chk_reload_pulse: assert property (s_powerup_changed |=> // see [RULE10]
      map_reloaded_o ##1 (!map_reloaded_o || !clk_en_i))
      else $error("reload pulse wrong");
   chk_brake_drive: assert property (clk_en_i && r.out_sel[1] == OUT_BRAKE |=> // see [RULE11]
      digital_output_two_o == $past(brake_release_i)) else $error("brake output wrong");
   chk_status_zero: assert property (r.in_status[15:7] == 9'h000 && // see [RULE12]
      r.out_status[15:3] == 13'h0000) else $error("unused status bits set");
endmodule : iofm_top
`default_nettype wire

//--- tb/iofm_partner.sv
// Machine-side model: switches on the input pins and the brake controller
`timescale 1ns/1ps
`default_nettype none
module iofm_partner (
   input  wire logic [6:0] switch_cmd_i,     // Switch positions, status bit order
   input  wire logic       brake_cmd_i,      // Brake release output of the drive
   output logic      [6:0] pin_o,            // Contact levels into the drive
   output logic            brake_released_o  // Brake controller state
);
   // Contacts are driven hard both ways, so the pins simply follow the switches
   assign pin_o = switch_cmd_i;
   // Brake opens while the command is high and closes when it drops
   assign brake_released_o = brake_cmd_i;
endmodule : iofm_partner
`default_nettype wire

//--- tb/testbench.sv
// Self-checking testbench for the configurable I/O function map
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import iofm_pkg::*;
   // ****************************************
   // Stimulus, observation and bookkeeping
   // ****************************************
   logic        clk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic [6:0]  sw = 7'h30;
   logic [6:0]  pin;
   logic [2:0]  mode = MODE_JOG;
   logic [2:0]  stored = MODE_GEAR;
   logic [3:0]  sel_in [4] = '{IN_NONE, IN_HALT, IN_NONE, IN_NONE};
   logic [2:0]  sel_out [3] = '{OUT_NONE, OUT_BRAKE, OUT_ACTIVE};
   logic        select_load = 1'b0;
   logic        clk_en = 1'b1;
   logic [3:0]  core = 4'h0;
   logic        param_rd = 1'b0;
   logic [15:0] param_addr = 16'h0000;
   logic [10:0] in_fn;
   logic        pse, spr, out1, out2, out3, reloaded, ack, err, brake;
   logic [15:0] rdata;
   int          error_cnt = 0;
   int          checked = 0;
   int          cycles = 0;
   int          pins [4] = '{0, 1, 3, 6};
   logic [3:0]  def_tab [6][4] = '{'{IN_JOG_NEG, IN_JOG_POS, IN_JOG_FAST, IN_ENABLE2},
      '{IN_NONE, IN_FAULT_RESET, IN_HALT, IN_ENABLE2}, '{IN_NONE, IN_FAULT_RESET, IN_HALT,
      IN_ENABLE2}, '{IN_NONE, IN_FAULT_RESET, IN_HALT, IN_ENABLE2},
      '{IN_REF, IN_NEGATIVE_LIMIT_SWITCH, IN_START, IN_ENABLE2}, '{IN_REF, IN_NEGATIVE_LIMIT_SWITCH, IN_HALT, IN_NONE}};
   logic [3:0]  pats [3] = '{4'h5, 4'ha, 4'h3};

   // Clock and the cycle ceiling that cuts a hang short
   always #2.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         end_of_test();
      end
   end

   // ****************************************
   // Design and machine model
   // ****************************************
   iofm_top u_iofm_top (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en),
      .digital_input_one_i(pin[0]), .digital_input_two_i(pin[1]),
      .digital_input_three_i(pin[2]), .digital_input_four_i(pin[3]),
      .safety_shutdown_input_a_i(pin[4]), .safety_shutdown_input_b_i(pin[5]),
      .digital_input_seven_i(pin[6]), .startup_mode_i(mode), .stored_mode_i(stored),
      .input_one_function_select_i(sel_in[0]), .input_two_function_select_i(sel_in[1]),
      .input_four_function_select_i(sel_in[2]), .input_seven_function_select_i(sel_in[3]),
      .output_one_function_select_i(sel_out[0]), .output_two_function_select_i(sel_out[1]),
      .output_three_function_select_i(sel_out[2]), .select_load_i(select_load),
      .no_fault_i(core[0]), .start_ack_i(core[1]), .brake_release_i(core[2]),
      .active_i(core[3]), .param_rd_i(param_rd), .param_addr_i(param_addr),
      .input_function_o(in_fn), .power_stage_enable_o(pse), .safe_power_removal_o(spr),
      .digital_output_one_o(out1), .digital_output_two_o(out2),
      .digital_output_three_o(out3), .map_reloaded_o(reloaded), .param_ack_o(ack),
      .param_err_o(err), .param_rdata_o(rdata));
   iofm_partner u_iofm_partner (.switch_cmd_i(sw), .brake_cmd_i(out2), .pin_o(pin),
      .brake_released_o(brake));

   // ****************************************
   // Helpers and access tasks
   // ****************************************
   function automatic logic [15:0] fn_bits(input logic [3:0] code);
      logic [15:0] r;
      r = 16'h0001 << code;
      r[0] = 1'b0;
      return r;
   endfunction : fn_bits

   function automatic logic out_exp(input logic [2:0] f, input logic [3:0] c);
      return (f == OUT_NONE) ? 1'b0 : c[f - 3'h1];
   endfunction : out_exp

   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %0t word got %h expected %h", $time, got, exp);
      end
   endtask : cmp_word

   task automatic cmp_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %0t bit got %b expected %b", $time, got, exp);
      end
   endtask : cmp_bit

   // Waits edges, then steps just past the last one where inputs may change
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick

   // Status read: request held over one edge, answer checked, then one idle edge
   task automatic rd(input logic [15:0] addr, input logic [15:0] exp, input logic e);
      param_addr = addr;
      param_rd = 1'b1;
      tick(1);
      param_rd = 1'b0;
      cmp_bit(ack, 1'b1);
      cmp_bit(err, e);
      cmp_word(rdata, exp);
      tick(1);
   endtask : rd

   // Power cycle with the given modes; counts reload pulses just after release
   task automatic power_up(input logic [2:0] m, input logic [2:0] s, input logic exp);
      int seen;
      seen = 0;
      reset_n_i = 1'b0;
      tick(2);
      mode = m;
      stored = s;
      reset_n_i = 1'b1;
      repeat (3) begin
         tick(1);
         if (reloaded === 1'b1) seen++;
      end
      cmp_bit(seen == 1, exp);
   endtask : power_up

   task automatic load_sel();
      select_load = 1'b1;
      tick(1);
      select_load = 1'b0;
      tick(1);
   endtask : load_sel

   // One configurable pin high alone, its function bit alone must follow
   task automatic pin_fn(input int p, input logic [3:0] code);
      sw = 7'h30 | (7'h01 << p);
      tick(3);
      cmp_word({5'h00, in_fn}, fn_bits(code));
   endtask : pin_fn

   task automatic out_chk(input logic [2:0] f1, input logic [2:0] f2, input logic [2:0] f3);
      for (int i = 0; i < 3; i++) begin
         core = pats[i];
         tick(3);
         cmp_bit(out1, out_exp(f1, core));
         cmp_bit(out2, out_exp(f2, core));
         cmp_bit(brake, out_exp(f2, core));
         cmp_bit(out3, out_exp(f3, core));
      end
   endtask : out_chk

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      tick(2);
      reset_n_i = 1'b1;
      rd(ADDR_INPUT_LEVEL, STATUS_RESET, 1'b0);
      rd(ADDR_OUTPUT_LEVEL, STATUS_RESET, 1'b0);
      // Factory defaults of every start-up mode after a mode change
      for (int m = 0; m < 6; m++) begin
         power_up(3'(m), 3'(m + 1), 1'b1);
         for (int p = 0; p < 4; p++) pin_fn(pins[p], def_tab[m][p]);
         out_chk((m == 4) ? OUT_START_ACK : OUT_NO_FAULT, OUT_BRAKE, OUT_ACTIVE);
         sw = 7'h34;
         tick(3);
         cmp_bit(pse, 1'b1);
         cmp_bit(in_fn[10], m == 5);
         sw = 7'h30;
      end
      power_up(MODE_JOG, MODE_JOG, 1'b0);
      // Every input function code except IN_NONE on input one, then a refused code on input two
      for (int c = 1; c < 11; c++) begin
         sel_in[0] = 4'(c);
         load_sel();
         pin_fn(0, 4'(c));
      end
      sel_in[1] = 4'hf;
      load_sel();
      pin_fn(1, IN_HALT);
      // Every output function code on output one, then a refused code
      for (int k = 0; k < 5; k++) begin
         sel_out[0] = 3'(k);
         load_sel();
         out_chk(3'(k), OUT_BRAKE, OUT_ACTIVE);
      end
      sel_out[0] = 3'h7;
      load_sel();
      out_chk(OUT_ACTIVE, OUT_BRAKE, OUT_ACTIVE);
      // Fixed pins keep their functions after loads
      sw = 7'h34;
      tick(3);
      cmp_bit(pse, 1'b1);
      // Clock enable low freezes the outputs while the pins move
      clk_en = 1'b0;
      sw = 7'h20;
      tick(3);
      cmp_bit(pse, 1'b1);
      cmp_bit(spr, 1'b0);
      clk_en = 1'b1;
      tick(3);
      cmp_bit(spr, 1'b1);
      cmp_bit(pse, 1'b0);
      sw = 7'h10;
      tick(3);
      cmp_bit(spr, 1'b1);
      sw = 7'h30;
      tick(3);
      cmp_bit(spr, 1'b0);
      // Live status words and an unmapped address
      core = 4'h5;
      sw = 7'h4b;
      tick(3);
      rd(ADDR_INPUT_LEVEL, 16'h004b, 1'b0);
      rd(ADDR_OUTPUT_LEVEL, 16'h0002, 1'b0);
      rd(16'h0822, 16'h0000, 1'b1);
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
